/* File: hw/nhc_defs.vh */
// Constants for the NAND host command controller.
`ifndef NHC_DEFS_VH
`define NHC_DEFS_VH
// ********************************
// Device command codes
// ********************************
`define NHC_C_READ1 8'h00
`define NHC_C_READ2 8'h30
`define NHC_C_PROG1 8'h80
`define NHC_C_PROG2 8'h10
`define NHC_C_ERAS1 8'h60
`define NHC_C_ERAS2 8'hD0
`define NHC_C_STAT 8'h70
`define NHC_C_RESET 8'hFF
// ********************************
// Operation codes in the control word
// ********************************
`define NHC_OP_RESET 3'h1
`define NHC_OP_STAT 3'h2
`define NHC_OP_PROG 3'h3
`define NHC_OP_ERASE 3'h4
`define NHC_OP_READ 3'h5
`define NHC_OP_SCAN 3'h6
// ********************************
// Register byte offsets
// ********************************
`define NHC_A_CTRL 8'h00
`define NHC_A_CFG 8'h04
`define NHC_A_COL 8'h08
`define NHC_A_ROW 8'h0C
`define NHC_A_WDAT 8'h10
`define NHC_A_RDAT 8'h14
`define NHC_A_STAT 8'h18
// ********************************
// Status byte bits and sticky flag bits
// ********************************
`define NHC_SB_FAIL 0
`define NHC_SB_PBRDY 5
`define NHC_F_REFUSE 2
`define NHC_F_FAIL 3
`define NHC_F_BAD 4
`define NHC_F_ECC 5
// ********************************
// Limits
// ********************************
`define NHC_BAD_MARK 8'h00
`define NHC_ECC_LIMIT 8'h08
`define NHC_PART_MAX 3'h4
`define NHC_LAST_ADDR 3'h4
`define NHC_ERASE_SKIP 3'h2
`endif

/* File: hw/nhc_top.v */
// NAND host command controller with an APB register slave.
`timescale 1ns/100ps
`include "nhc_defs.vh"
module nhc_top
#(
  parameter [7:0] DIV = 8'h04,
  parameter PAGE_BITS = 6,
  parameter BLOCK_BITS = 11
)
(
  // Clock and reset.
  input wire clk,
  input wire reset,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Device pins.
  output reg ce_n,
  output reg cle,
  output reg ale,
  output reg we_n,
  output reg read_strobe_n,
  output reg wp_n,
  output reg [7:0] io_out,
  output reg io_oe,
  input wire [7:0] io_in,
  input wire ready_busy_line,
  // Corrected-error count from the read data ECC engine.
  input wire ecc_valid,
  input wire [7:0] ecc_err_cnt
);
  // ********************************
  // Declarations
  // ********************************
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_CMD1 = 4'h1;
  localparam [3:0] S_ADDR = 4'h2;
  localparam [3:0] S_DATW = 4'h3;
  localparam [3:0] S_CMD2 = 4'h4;
  localparam [3:0] S_PCMD = 4'h5;
  localparam [3:0] S_PRD = 4'h6;
  localparam [3:0] S_EXIT = 4'h7;
  localparam [3:0] S_DATR = 4'h8;
  localparam BLOCKS = 1 << BLOCK_BITS;
  reg [7:0] io_s1_reg, io_s2_reg; // Data pin synchroniser.
  reg rb_s1_reg, rb_s2_reg; // Busy line synchroniser.
  reg [7:0] div_reg; // Pin phase divider.
  reg [3:0] state_reg; // Sequencer state.
  reg ph_reg; // Strobe phase: 0 assert, 1 release.
  reg [2:0] op_reg; // Running operation.
  reg [2:0] aidx_reg; // Address cycle counter.
  reg [15:0] col_reg; // Column address.
  reg [23:0] row_reg; // Row address: block and page.
  reg [7:0] wdat_reg, rdat_reg; // Data byte out and in.
  reg [7:0] stat_reg; // Last status byte seen.
  reg init_reg; // Power-up reset finished.
  reg refuse_reg, fail_reg, badf_reg, ecc_reg; // Sticky flags.
  reg [BLOCKS-1:0] bad_reg; // Bad block table.
  reg trk_reg; // Program tracking valid.
  reg [BLOCK_BITS-1:0] trk_blk_reg; // Block being filled.
  reg [PAGE_BITS-1:0] trk_pg_reg; // Last page programmed.
  reg [2:0] part_reg; // Partial programs on that page.
  reg [7:0] cur_byte; // Byte to drive this cycle.
  reg [2:0] k; // Address byte number.
  wire tick = (div_reg == DIV - 8'h01);
  wire idle = (state_reg == S_IDLE);
  wire [PAGE_BITS-1:0] pg = row_reg[PAGE_BITS-1:0];
  wire [BLOCK_BITS-1:0] blk = row_reg[PAGE_BITS +: BLOCK_BITS];
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire wr_ctrl = wr & (paddr == `NHC_A_CTRL);
  wire wr_stat = wr & (paddr == `NHC_A_STAT);
  wire [2:0] nop = pwdata[2:0];
  wire is_pe = (nop == `NHC_OP_PROG) | (nop == `NHC_OP_ERASE);
  wire known = (nop >= `NHC_OP_RESET) & (nop <= `NHC_OP_SCAN);
  // Only the init-safe commands are allowed before the first reset ends.
  wire early_ok = init_reg | (nop == `NHC_OP_RESET) |
                  (nop == `NHC_OP_STAT);
  // Same page may be programmed again only while partials remain.
  wire same = trk_reg & (blk == trk_blk_reg);
  wire order_bad = (nop == `NHC_OP_PROG) & same &
                   ((pg < trk_pg_reg) | ((pg == trk_pg_reg) &
                   (part_reg >= `NHC_PART_MAX)));
  wire bad_hit = is_pe & bad_reg[blk];
  // A new order is only taken when the device is not busy with ours.
  wire go_ok = known & idle & early_ok & ~order_bad & ~bad_hit;
  wire sb_rdy = io_s2_reg[`NHC_SB_PBRDY];
  // ********************************
  // Input synchronisers
  // ********************************
  // Pins come from another timing domain, so two flops each.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      io_s1_reg <= 8'h00;
      io_s2_reg <= 8'h00;
      rb_s1_reg <= 1'b0;
      rb_s2_reg <= 1'b0;
    end
    else
    begin
      io_s1_reg <= io_in;
      io_s2_reg <= io_s1_reg;
      rb_s1_reg <= ready_busy_line;
      rb_s2_reg <= rb_s1_reg;
    end
  end
  // ********************************
  // Byte selection
  // ********************************
  // Picks the byte for the current write cycle; only defined codes exist.
  always @*
  begin
    k = aidx_reg;
    if (op_reg == `NHC_OP_ERASE)
      k = aidx_reg + `NHC_ERASE_SKIP; // Erase sends row bytes only.
    cur_byte = `NHC_C_STAT;
    case (state_reg)
      S_CMD1:
        case (op_reg)
          `NHC_OP_RESET: cur_byte = `NHC_C_RESET;
          `NHC_OP_PROG: cur_byte = `NHC_C_PROG1;
          `NHC_OP_ERASE: cur_byte = `NHC_C_ERAS1;
          `NHC_OP_READ: cur_byte = `NHC_C_READ1;
          `NHC_OP_SCAN: cur_byte = `NHC_C_READ1;
          default: cur_byte = `NHC_C_STAT;
        endcase
      S_ADDR:
        case (k)
          3'h0: cur_byte = col_reg[7:0];
          3'h1: cur_byte = col_reg[15:8];
          3'h2: cur_byte = row_reg[7:0];
          3'h3: cur_byte = row_reg[15:8];
          default: cur_byte = row_reg[23:16]; // Five cycles (three for erase), no sixth.
        endcase
      S_DATW: cur_byte = wdat_reg;
      S_CMD2:
        case (op_reg)
          `NHC_OP_PROG: cur_byte = `NHC_C_PROG2;
          `NHC_OP_ERASE: cur_byte = `NHC_C_ERAS2;
          default: cur_byte = `NHC_C_READ2;
        endcase
      S_EXIT: cur_byte = `NHC_C_READ1; // Leaves status mode.
      default: cur_byte = `NHC_C_STAT;
    endcase
  end
  // ********************************
  // Pin divider
  // ********************************
  // Each strobe phase lasts DIV clocks, giving the pins setup time.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      div_reg <= 8'h00;
    else if (tick)
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end
  // ********************************
  // Sequencer, flags and bad block table
  // ********************************
  // Leaves reset already issuing the power-up reset command.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= S_CMD1;
      op_reg <= `NHC_OP_RESET;
      ph_reg <= 1'b0;
      aidx_reg <= 3'h0;
      rdat_reg <= 8'h00;
      stat_reg <= 8'h00;
      init_reg <= 1'b0;
      refuse_reg <= 1'b0;
      fail_reg <= 1'b0;
      badf_reg <= 1'b0;
      ecc_reg <= 1'b0;
      bad_reg <= {BLOCKS{1'b0}};
      trk_reg <= 1'b0;
      trk_blk_reg <= {BLOCK_BITS{1'b0}};
      trk_pg_reg <= {PAGE_BITS{1'b0}};
      part_reg <= 3'h0;
      ce_n <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      read_strobe_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end
    else
    begin
      // Software clears sticky flags first so a same-cycle set wins.
      if (wr_stat)
      begin
        refuse_reg <= refuse_reg & ~pwdata[`NHC_F_REFUSE];
        fail_reg <= fail_reg & ~pwdata[`NHC_F_FAIL];
        badf_reg <= badf_reg & ~pwdata[`NHC_F_BAD];
        ecc_reg <= ecc_reg & ~pwdata[`NHC_F_ECC];
      end
      // Corrected errors never retire a block; only flagged if too many.
      if (ecc_valid & (ecc_err_cnt > `NHC_ECC_LIMIT))
        ecc_reg <= 1'b1;
      // A refused order only raises its flag; it must never swallow a
      // divider tick, or a strobe in flight would be stretched.
      if (wr_ctrl & ~go_ok)
        refuse_reg <= 1'b1;
      if (wr_ctrl & go_ok)
      begin
        op_reg <= nop;
        state_reg <= S_CMD1;
        aidx_reg <= 3'h0;
        ph_reg <= 1'b0;
        if (nop == `NHC_OP_PROG)
        begin
          trk_reg <= 1'b1;
          trk_blk_reg <= blk;
          trk_pg_reg <= pg;
          part_reg <= (same & (pg == trk_pg_reg)) ?
                      part_reg + 3'h1 : 3'h1;
        end
        if ((nop == `NHC_OP_ERASE) & same)
          trk_reg <= 1'b0; // Erased block may be filled from page 0.
      end
      else if (tick & ~idle & ~ph_reg)
      begin
        // Assert phase: drive the strobe and the latches.
        ph_reg <= 1'b1;
        ce_n <= 1'b0;
        if ((state_reg == S_PRD) | (state_reg == S_DATR))
        begin
          read_strobe_n <= 1'b0;
          io_oe <= 1'b0;
          cle <= 1'b0;
          ale <= 1'b0;
        end
        else
        begin
          we_n <= 1'b0;
          io_out <= cur_byte;
          io_oe <= 1'b1;
          cle <= (state_reg != S_ADDR) & (state_reg != S_DATW);
          ale <= (state_reg == S_ADDR);
        end
      end
      else if (tick & ~idle)
      begin
        // Release phase: the device latches or we sample, then advance.
        ph_reg <= 1'b0;
        we_n <= 1'b1;
        read_strobe_n <= 1'b1;
        case (state_reg)
          S_CMD1:
            if (op_reg == `NHC_OP_RESET)
              state_reg <= S_PCMD;
            else if (op_reg == `NHC_OP_STAT)
              state_reg <= S_PRD;
            else
              state_reg <= S_ADDR;
          S_ADDR:
          begin
            aidx_reg <= aidx_reg + 3'h1;
            if (k == `NHC_LAST_ADDR)
              state_reg <= (op_reg == `NHC_OP_PROG) ? S_DATW : S_CMD2;
          end
          S_DATW: state_reg <= S_CMD2;
          S_CMD2: state_reg <= S_PCMD;
          // Busy is judged from status, so a shared busy wire is harmless.
          S_PCMD: state_reg <= S_PRD;
          S_PRD:
          begin
            stat_reg <= io_s2_reg;
            if (op_reg == `NHC_OP_STAT)
              state_reg <= S_IDLE;
            else if (sb_rdy)
            begin
              // Pass/fail is read only now, after our op and when ready.
              if (((op_reg == `NHC_OP_PROG) | (op_reg == `NHC_OP_ERASE))
                  & io_s2_reg[`NHC_SB_FAIL])
              begin
                fail_reg <= 1'b1;
                badf_reg <= 1'b1;
                bad_reg[blk] <= 1'b1;
              end
              if (op_reg == `NHC_OP_RESET)
                init_reg <= 1'b1;
              if ((op_reg == `NHC_OP_READ) | (op_reg == `NHC_OP_SCAN))
                state_reg <= S_EXIT;
              else
                state_reg <= S_IDLE;
            end
          end
          S_EXIT: state_reg <= S_DATR;
          S_DATR:
          begin
            rdat_reg <= io_s2_reg;
            if ((op_reg == `NHC_OP_SCAN) & (io_s2_reg == `NHC_BAD_MARK))
            begin
              bad_reg[blk] <= 1'b1;
              badf_reg <= 1'b1;
            end
            state_reg <= S_IDLE;
          end
          default: state_reg <= S_IDLE;
        endcase
        if ((state_reg == S_DATR) | ((state_reg == S_PRD) &
            ((op_reg == `NHC_OP_STAT) | (sb_rdy &
            (op_reg != `NHC_OP_READ) & (op_reg != `NHC_OP_SCAN)))))
        begin
          ce_n <= 1'b1;
          cle <= 1'b0;
          ale <= 1'b0;
          io_oe <= 1'b0;
        end
      end
    end
  end
  // ********************************
  // APB slave
  // ********************************
  // One wait state: pready rises in the cycle after the access begins.
  // The write lands at the edge pready is seen; the read data lands one edge earlier, with pready.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      wp_n <= 1'b0; // Protected until software allows writes.
      col_reg <= 16'h0000;
      row_reg <= 24'h000000;
      wdat_reg <= 8'h00;
    end
    else if (psel & penable & ~pready)
    begin
      pready <= 1'b1;
      pslverr <= (paddr > `NHC_A_STAT) | (paddr[1:0] != 2'h0);
      case (paddr)
        `NHC_A_CFG: prdata <= {31'h00000000, wp_n};
        `NHC_A_COL: prdata <= {16'h0000, col_reg};
        `NHC_A_ROW: prdata <= {8'h00, row_reg};
        `NHC_A_WDAT: prdata <= {24'h000000, wdat_reg};
        `NHC_A_RDAT: prdata <= {24'h000000, rdat_reg};
        `NHC_A_STAT: prdata <= {16'h0000, stat_reg, bad_reg[blk],
                                rb_s2_reg, ecc_reg, badf_reg, fail_reg,
                                refuse_reg, init_reg, ~idle};
        default: prdata <= 32'h00000000;
      endcase
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (wr & idle)
        case (paddr)
          // Low write protect makes the device abort program and erase.
          `NHC_A_CFG: wp_n <= pwdata[0];
          `NHC_A_COL: col_reg <= pwdata[15:0];
          `NHC_A_ROW: row_reg <= pwdata[23:0];
          `NHC_A_WDAT: wdat_reg <= pwdata[7:0];
          default: wdat_reg <= wdat_reg;
        endcase
    end
  end
endmodule

/* File: test/nhc_props.sv */
// Pin and bus checker for the NAND host controller.
`timescale 1ns/100ps
module nhc_props
(
  // Clock, reset and bus answer.
  input wire clk,
  input wire reset,
  input wire pready,
  input wire pslverr,
  // Device pins.
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire read_strobe_n,
  input wire [7:0] io_out,
  input wire io_oe,
  input wire ready_busy_line
);
  // ********
  // Shadow of the command stream
  // ********
  reg we_q;
  reg seen;
  reg pv;
  reg [7:0] last;
  reg [23:0] sr;
  reg [16:0] prow;
  reg [2:0] pcnt;
  // A byte is latched by the device when the write strobe rises.
  wire lat = we_n & ~we_q & ~ce_n;
  wire cs = lat & cle;
  wire same = pv & (sr[16:0] == prow);
  // Tracks last command, row address and programs of the last page.
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      we_q <= 1'b1;
      seen <= 1'b0;
      pv <= 1'b0;
      last <= 8'h00;
      sr <= 24'h000000;
      prow <= 17'h00000;
      pcnt <= 3'h0;
    end
    else
    begin
      we_q <= we_n;
      if (lat & ale)
        sr <= {io_out, sr[23:8]};
      if (cs)
      begin
        last <= io_out;
        seen <= 1'b1;
        // An erase restarts page order, so tracking is dropped.
        pv <= (io_out == 8'h10) | (pv & (io_out != 8'hD0));
        if (io_out == 8'h10)
        begin
          prow <= sr[16:0];
          pcnt <= same ? pcnt + 3'h1 : 3'h1;
        end
      end
    end
  end
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ********
  // Properties
  // ********
  property p_known;
    cs |-> io_out inside {8'h00, 8'h30, 8'h80, 8'h10, 8'h60, 8'hD0,
      8'h70, 8'hFF};
  endproperty
  a_known: assert property (p_known) else $error("unknown code");
  property p_busy;
    cs && !ready_busy_line |-> io_out inside {8'h70, 8'h71, 8'hFF};
  endproperty
  a_busy: assert property (p_busy) else $error("busy command");
  property p_seq80;
    cs && last == 8'h80 |-> io_out inside {8'h85, 8'h10, 8'h11, 8'h15,
      8'hFF};
  endproperty
  a_seq80: assert property (p_seq80) else $error("after 80");
  property p_first;
    cs && !seen |-> io_out == 8'hFF;
  endproperty
  a_first: assert property (p_first) else $error("first");
  property p_poll;
    cs && (last == 8'h10 || last == 8'hD0) |-> io_out == 8'h70;
  endproperty
  a_poll: assert property (p_poll) else $error("no poll");
  property p_order;
    cs && io_out == 8'h10 && pv && sr[16:6] == prow[16:6] |->
      sr[5:0] >= prow[5:0];
  endproperty
  a_order: assert property (p_order) else $error("page order");
  property p_part;
    cs && io_out == 8'h10 && same |-> pcnt < 3'h4;
  endproperty
  a_part: assert property (p_part) else $error("partial");
  property p_we_len;
    $fell(we_n) |-> !we_n [*4] ##1 we_n;
  endproperty
  a_we_len: assert property (p_we_len) else $error("strobe length");
  property p_err;
    pslverr |-> pready ##1 !pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  // The data pins are driven during write strobes and released for reads.
  property p_oe;
    (!we_n || !read_strobe_n) |-> (io_oe == !we_n);
  endproperty
  a_oe: assert property (p_oe) else $error("data drive direction");
endmodule
bind nhc_top nhc_props u_nhc_props (.clk(clk), .reset(reset),
  .pready(pready), .pslverr(pslverr), .ce_n(ce_n), .cle(cle), .ale(ale),
  .we_n(we_n), .read_strobe_n(read_strobe_n), .io_out(io_out),
  .io_oe(io_oe), .ready_busy_line(ready_busy_line));

/* File: test/nhc_flash_model.sv */
// Behavioural model of the flash device on the controller pins.
`timescale 1ns/100ps
module nhc_flash_model
#(
  parameter BUSY = 40
)
(
  // Bench clock, used only to time the busy period.
  input wire clk,
  // Device pins.
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire read_strobe_n,
  input wire wp_n,
  input wire [7:0] io_out,
  output wire [7:0] io_in,
  output wire ready_busy_line,
  // Faults commanded by the bench.
  input wire fail_next,
  input wire [10:0] bad_blk
);
  reg [7:0] mem [0:255];
  reg [7:0] data = 8'h00;
  reg [7:0] dout = 8'h00;
  reg [23:0] sr = 24'h000000;
  reg stmode = 1'b0;
  reg fail = 1'b0;
  reg go = 1'b0;
  reg go_d = 1'b0;
  integer cnt = BUSY;
  integer na = 0; // Address cycles since the last command.
  integer i;
  wire rdy = (cnt == 0);
  // Busy from power-up; the line is driven high and low straight from rdy.
  assign ready_busy_line = rdy;
  // A released bus shows the inverse of the last byte, not a held value.
  assign io_in = (!ce_n && !read_strobe_n) ? dout : ~dout;
  initial
    for (i = 0; i < 256; i = i + 1)
      mem[i] = 8'hFF;
  // Busy counter restarts on every operation launch.
  always @(posedge clk)
  begin
    go_d <= go;
    if (go != go_d)
      cnt <= BUSY;
    else if (cnt != 0)
      cnt <= cnt - 1;
  end
  // Commands, addresses and data are taken on the rising write strobe.
  always @(posedge we_n)
    if (!ce_n)
    begin
      if (cle)
      begin
        na <= 0;
        if (io_out == 8'h70 || io_out == 8'h00)
          stmode <= (io_out == 8'h70);
        if (io_out == 8'hFF || io_out == 8'h10 || io_out == 8'hD0 ||
          io_out == 8'h30)
          go <= ~go;
        if (io_out == 8'hFF)
          fail <= 1'b0;
        if (io_out == 8'h10 || io_out == 8'hD0)
          fail <= fail_next | ~wp_n;
        // Data only commits on confirm; anything else drops it.
        if (io_out == 8'h10 && wp_n && !fail_next)
          mem[sr[7:0]] <= data;
      end
      else if (ale)
      begin
        // A sixth address cycle is taken in but has no effect.
        if (na < 5)
          sr <= {io_out, sr[23:8]};
        na <= na + 1;
      end
      else
        data <= io_out;
    end
  // Status or array byte appears on each falling read strobe.
  always @(negedge read_strobe_n)
    if (!ce_n)
      dout <= stmode ? {wp_n, rdy, rdy, 4'h0, fail} :
        (sr[16:6] == bad_blk) ? 8'h00 : mem[sr[7:0]];
endmodule

/* File: test/nhc_top_bench.sv */
// Self-checking bench for the NAND host controller.
`timescale 1ns/100ps
`include "nhc_defs.vh"
module nhc_top_bench;
  reg clk;
  reg reset;
  reg psel;
  reg penable;
  reg pwrite;
  reg ecc_valid;
  reg fail_next;
  reg er;
  reg refd;
  reg [7:0] paddr;
  reg [7:0] ecc_err_cnt;
  reg [7:0] d;
  reg [10:0] bad_blk;
  reg [31:0] pwdata;
  reg [31:0] rd;
  reg [5:0] p;
  reg [5:0] lastp;
  wire [31:0] prdata;
  wire pready, pslverr, ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe;
  wire ready_busy_line;
  wire [7:0] io_out;
  wire [7:0] io_in;
  integer errors = 0;
  integer n_compared = 0;
  integer k;
  integer i;
  integer pc;
  int exp_mem[int];
  int pages[7] = '{0, 1, 1, 1, 1, 1, 0};
  int codes[4] = '{1, 2, 0, 7};
  nhc_top u_nhc_top (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n(ce_n),
    .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n),
    .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
    .ready_busy_line(ready_busy_line), .ecc_valid(ecc_valid),
    .ecc_err_cnt(ecc_err_cnt));
  nhc_flash_model u_nhc_flash_model (.clk(clk), .ce_n(ce_n), .cle(cle),
    .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n), .wp_n(wp_n),
    .io_out(io_out), .io_in(io_in), .ready_busy_line(ready_busy_line),
    .fail_next(fail_next), .bad_blk(bad_blk));
  // Compares one value and counts it.
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      errors = errors + 1;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  // One bus transfer; holds the request until ready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
  begin
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // Launches an order and polls status until idle; x adds a busy order.
  task run(input logic [2:0] o, input logic [16:0] r, input logic x);
  begin
    apb(1'b1, `NHC_A_STAT, 32'h3C);
    apb(1'b1, `NHC_A_ROW, {15'h0, r});
    apb(1'b1, `NHC_A_WDAT, {24'h0, d});
    apb(1'b1, `NHC_A_CTRL, {29'h0, o});
    if (x)
      apb(1'b1, `NHC_A_CTRL, {29'h0, `NHC_OP_STAT});
    k = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && k < 3000)
    begin
      apb(1'b0, `NHC_A_STAT, 32'h0);
      k = k + 1;
    end
    if (k == 3000)
      errors = errors + 1;
  end
  endtask
  // Prints the counts and the verdict, then stops.
  task final_report;
  begin
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // A hang costs far more than the whole run should take.
  initial
  begin
    #400000;
    errors = errors + 1;
    final_report;
  end
  initial
  begin
    reset = 1'b1;
    {psel, penable, pwrite, ecc_valid, fail_next} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    ecc_err_cnt = 8'h00;
    bad_blk = 11'h7FF;
    d = 8'h00;
    k = $urandom(32'hEB11);
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    apb(1'b1, `NHC_A_CTRL, {29'h0, `NHC_OP_PROG});
    apb(1'b0, `NHC_A_STAT, 32'h0);
    chk("refused", 1, rd[2]);
    k = 0;
    while (rd[1] !== 1'b1 && k < 3000)
    begin
      apb(1'b0, `NHC_A_STAT, 32'h0);
      k = k + 1;
    end
    if (k == 3000)
      errors = errors + 1;
    chk("init", 1, rd[1]);
    chk("sbyte", 8'h60, rd[15:8]);
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", 1, er);
    apb(1'b0, 8'h02, 32'h0);
    chk("slverr", 1, er);
    apb(1'b1, `NHC_A_CFG, 32'h1);
    lastp = 6'h0;
    pc = 0;
    for (i = 0; i < 7; i = i + 1)
    begin
      p = pages[i];
      refd = (i > 0) && (p < lastp || (p == lastp && pc == 4));
      d = $urandom;
      run(`NHC_OP_PROG, {11'h3, p}, i == 0);
      chk("refused", refd || i == 0, rd[2]);
      if (!refd)
      begin
        pc = (i > 0 && p == lastp) ? pc + 1 : 1;
        lastp = p;
        exp_mem[p] = d;
        chk("sbyte", 8'hE0, rd[15:8]);
        run(`NHC_OP_READ, {11'h3, p}, 1'b0);
        apb(1'b0, `NHC_A_RDAT, 32'h0);
        chk("rdat", exp_mem[p], rd[7:0]);
      end
    end
    fail_next <= 1'b1;
    run(`NHC_OP_PROG, {11'h5, 6'h0}, 1'b0);
    fail_next <= 1'b0;
    chk("opfail", 1, rd[3]);
    chk("badrow", 1, rd[7]);
    chk("sbyte", 8'hE1, rd[15:8]);
    run(`NHC_OP_ERASE, {11'h5, 6'h0}, 1'b0);
    chk("refused", 1, rd[2]);
    run(`NHC_OP_PROG, {11'h5, 6'h1}, 1'b0);
    chk("refused", 1, rd[2]);
    bad_blk <= 11'h9;
    run(`NHC_OP_SCAN, {11'h9, 6'h0}, 1'b0);
    chk("badmark", 1, rd[4]);
    run(`NHC_OP_ERASE, {11'h9, 6'h0}, 1'b0);
    chk("refused", 1, rd[2]);
    run(`NHC_OP_ERASE, {11'h3, 6'h0}, 1'b0);
    chk("refused", 0, rd[2]);
    chk("sbyte", 8'hE0, rd[15:8]);
    chk("badrow", 0, rd[7]);
    apb(1'b1, `NHC_A_CFG, 32'h0);
    run(`NHC_OP_PROG, {11'h7, 6'h0}, 1'b0);
    chk("sbyte", 8'h61, rd[15:8]);
    for (i = 0; i < 4; i = i + 1)
    begin
      run(codes[i], 17'h0, 1'b0);
      chk("refused", codes[i] == 0 || codes[i] == 7, rd[2]);
      chk("sbyte", 8'h60, rd[15:8]);
    end
    for (i = 8; i < 10; i = i + 1)
    begin
      apb(1'b1, `NHC_A_STAT, 32'h3C);
      ecc_err_cnt <= i;
      ecc_valid <= 1'b1;
      @(posedge clk);
      ecc_valid <= 1'b0;
      apb(1'b0, `NHC_A_STAT, 32'h0);
      chk("ecc", i > 8, rd[5]);
      chk("badmark", 0, rd[4]);
    end
    final_report;
  end
endmodule
